// ### rtl/rxfl_map.svh
// Purpose: Register offsets, field positions, reset values and decode constants of the receive depth shadow bank.
// Assumes: Byte offsets on the plain register port; 16-bit registers.
// Notes:   Definitions only.
`ifndef RXFL_MAP_SVH
`define RXFL_MAP_SVH

// ==========================================================================
// Offsets
`define RXFL_ADDR_W          8
`define RXFL_OFF_DEPTH_MODE  8'h3A
`define RXFL_OFF_LAST_LEN    8'h3C

// ==========================================================================
// Fields and reset values
`define RXFL_SEL_W           4
`define RXFL_SEL_RST         4'h4
`define RXFL_SEL_MAX         4'hD
`define RXFL_LEN_RST         16'h0000
`define RXFL_ZERO16          16'h0000
`define RXFL_RSVD_ZERO       12'h000
`define RXFL_REG_W           16
`define RXFL_SEL_MIN         4'h0

// ==========================================================================
// Depth decode, in bits; one-byte length step
`define RXFL_DEPTH_BASE      7'h0C
`define RXFL_DEPTH_STEP_SH   2
`define RXFL_DEPTH_EXT       7'h20
`define RXFL_DEPTH_LONG      7'h40
`define RXFL_DEPTH_RST       7'h1C
`define RXFL_DEPTH_MAX       7'h40
`define RXFL_LEN_ONE         16'h0001

`endif

// ### rtl/rxfl_pkg.sv
// Purpose: Types shared by the receive depth shadow bank.
// Assumes: Constants live in rxfl_map.svh.
// Notes:   Types only.
package rxfl_pkg;

  typedef struct packed {
    logic [3:0]  depth_sel;
    logic [15:0] count;
    logic [15:0] last_len;
    logic        in_frame;
    logic [15:0] rd_data;
  } rxfl_state_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
  } rxfl_rx_t;

endpackage

// ### rtl/rxfl_regs.sv
// Purpose: Receive elastic buffer depth selector and last received frame length shadow registers.
// Assumes: Single clock; register port reads answer in the following cycle.
// Notes:   Accesses are gated by shadow_en; codes above thirteen decode as the deepest size, never an undefined one.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "rxfl_map.svh"

// Operation
// - Four-bit read/write depth selector in mode register low bits, resets to code 0100.
// - Code zero gives 12 bits; each step adds four, code thirteen gives 64.
// - Legacy buffer-extend and long-frame enable inputs may also set the depth.
// - Sixteen-bit read-only byte count of the last received frame, zero after reset.
// - Byte count is meaningful only while a valid link is up.
// - Upper mode bits are written as zero and read back as zero.
module rxfl_regs
  import rxfl_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic [`RXFL_ADDR_W-1:0]  reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [15:0]              reg_rdata,
  input  wire logic                     shadow_en,
  input  wire logic                     legacy_ext_en,
  input  wire logic                     legacy_long_en,
  input  wire logic                     link_up,
  input  wire rxfl_rx_t                 rx,
  output logic      [6:0]               rx_depth_bits,
  output logic                          last_len_valid
);

  rxfl_state_t st_r;
  rxfl_state_t st_nxt;
  logic        acc;

  assign acc = shadow_en;

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.rd_data = `RXFL_ZERO16;
    if (reg_wr && acc && reg_addr == `RXFL_OFF_DEPTH_MODE) begin
      st_nxt.depth_sel = reg_wdata[`RXFL_SEL_W-1:0];
    end
    if (reg_rd && acc) begin
      case (reg_addr)
        `RXFL_OFF_DEPTH_MODE: st_nxt.rd_data = {`RXFL_RSVD_ZERO, st_r.depth_sel};
        `RXFL_OFF_LAST_LEN:   st_nxt.rd_data = st_r.last_len;
        default:              st_nxt.rd_data = `RXFL_ZERO16;
      endcase
    end
    if (rx.valid) begin
      if (rx.sof) begin
        st_nxt.count    = `RXFL_LEN_ONE;
        st_nxt.in_frame = !rx.eof;
      end else if (st_r.in_frame) begin
        st_nxt.count = st_r.count + `RXFL_LEN_ONE;
      end
      if (rx.eof && (rx.sof || st_r.in_frame)) begin
        st_nxt.last_len = rx.sof ? `RXFL_LEN_ONE : st_r.count + `RXFL_LEN_ONE;
        st_nxt.in_frame = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{depth_sel: `RXFL_SEL_RST, count: `RXFL_ZERO16, last_len: `RXFL_LEN_RST,
                in_frame: 1'b0, rd_data: `RXFL_ZERO16};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rd_data;

  // ==========================================================================
  // Depth decode
  logic [3:0] eff_sel;
  assign eff_sel = (st_r.depth_sel > `RXFL_SEL_MAX) ? `RXFL_SEL_MAX : st_r.depth_sel;

  always_comb begin
    rx_depth_bits = `RXFL_DEPTH_BASE + (7'(eff_sel) << `RXFL_DEPTH_STEP_SH);
    if (legacy_long_en) begin
      rx_depth_bits = `RXFL_DEPTH_LONG;
    end else if (legacy_ext_en) begin
      rx_depth_bits = `RXFL_DEPTH_EXT;
    end
  end

  assign last_len_valid = link_up;

  // ==========================================================================
  // Assertions
  // selector reset value
  property p_sel_reset_val;
    @(posedge clock)
      $rose(rst_b) |->
      st_r.depth_sel == `RXFL_SEL_RST;
  endproperty
  a_sel_reset_val: assert property (p_sel_reset_val)
    else $error("Selector reset value wrong.");

  property p_len_reset;
    @(posedge clock)
      $rose(rst_b) |->
      st_r.last_len == `RXFL_LEN_RST;
  endproperty
  a_len_reset: assert property (p_len_reset)
    else $error("Length reset value wrong.");

  property p_sel_write_takes;
    @(posedge clock) disable iff (!rst_b)
      reg_wr && acc && reg_addr == `RXFL_OFF_DEPTH_MODE |=>
      st_r.depth_sel == $past(reg_wdata[`RXFL_SEL_W-1:0]);
  endproperty
  a_sel_write_takes: assert property (p_sel_write_takes)
    else $error("Selector write lost.");

  property p_no_access;
    @(posedge clock) disable iff (!rst_b)
      reg_wr && !acc |=>
      $stable(st_r.depth_sel);
  endproperty
  a_no_access: assert property (p_no_access)
    else $error("Write accepted without shadow access.");

  property p_mode_read;
    @(posedge clock) disable iff (!rst_b)
      reg_rd && acc && reg_addr == `RXFL_OFF_DEPTH_MODE |=>
      reg_rdata == {`RXFL_RSVD_ZERO, $past(st_r.depth_sel)};
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("Mode read data wrong.");

  property p_rsvd_zero;
    @(posedge clock) disable iff (!rst_b)
      reg_rd && reg_addr == `RXFL_OFF_DEPTH_MODE |=>
      reg_rdata[`RXFL_REG_W-1:`RXFL_SEL_W] == `RXFL_RSVD_ZERO;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved bits not zero.");

  property p_unmapped_read;
    @(posedge clock) disable iff (!rst_b)
      reg_rd && reg_addr != `RXFL_OFF_DEPTH_MODE && reg_addr != `RXFL_OFF_LAST_LEN |=>
      reg_rdata == `RXFL_ZERO16;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read not zero.");

  property p_rdata_idle;
    @(posedge clock) disable iff (!rst_b)
      !reg_rd |=>
      reg_rdata == `RXFL_ZERO16;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data not zero outside a read.");

  property p_gated_read;
    @(posedge clock) disable iff (!rst_b)
      reg_rd && !acc |=>
      reg_rdata == `RXFL_ZERO16;
  endproperty
  a_gated_read: assert property (p_gated_read)
    else $error("Read answered without shadow access.");

  property p_depth_decode;
    @(posedge clock) disable iff (!rst_b)
      !legacy_long_en && !legacy_ext_en && st_r.depth_sel == `RXFL_SEL_MIN |->
      rx_depth_bits == `RXFL_DEPTH_BASE;
  endproperty
  a_depth_decode: assert property (p_depth_decode)
    else $error("Depth code zero not 12 bits.");

  property p_depth_rst_code;
    @(posedge clock) disable iff (!rst_b)
      !legacy_long_en && !legacy_ext_en && st_r.depth_sel == `RXFL_SEL_RST |->
      rx_depth_bits == `RXFL_DEPTH_RST;
  endproperty
  a_depth_rst_code: assert property (p_depth_rst_code)
    else $error("Reset code depth not 28 bits.");

  property p_depth_top;
    @(posedge clock) disable iff (!rst_b)
      !legacy_long_en && !legacy_ext_en && st_r.depth_sel == `RXFL_SEL_MAX |->
      rx_depth_bits == `RXFL_DEPTH_MAX;
  endproperty
  a_depth_top: assert property (p_depth_top)
    else $error("Top code depth not 64 bits.");

  property p_depth_clamp;
    @(posedge clock) disable iff (!rst_b)
      !legacy_long_en && !legacy_ext_en && st_r.depth_sel > `RXFL_SEL_MAX |->
      rx_depth_bits == `RXFL_DEPTH_MAX;
  endproperty
  a_depth_clamp: assert property (p_depth_clamp)
    else $error("Spare code depth not clamped.");

  property p_legacy_long;
    @(posedge clock) disable iff (!rst_b)
      legacy_long_en |->
      rx_depth_bits == `RXFL_DEPTH_LONG;
  endproperty
  a_legacy_long: assert property (p_legacy_long)
    else $error("Long frame depth wrong.");

  property p_legacy_ext;
    @(posedge clock) disable iff (!rst_b)
      legacy_ext_en && !legacy_long_en |->
      rx_depth_bits == `RXFL_DEPTH_EXT;
  endproperty
  a_legacy_ext: assert property (p_legacy_ext)
    else $error("Extended depth wrong.");

  property p_len_hold;
    @(posedge clock) disable iff (!rst_b)
      !(rx.valid && rx.eof) |=>
      $stable(st_r.last_len);
  endproperty
  a_len_hold: assert property (p_len_hold)
    else $error("Length changed without frame end.");

  property p_len_single;
    @(posedge clock) disable iff (!rst_b)
      rx.valid && rx.sof && rx.eof |=>
      st_r.last_len == `RXFL_LEN_ONE;
  endproperty
  a_len_single: assert property (p_len_single)
    else $error("Single byte frame length wrong.");

  property p_len_capture;
    @(posedge clock) disable iff (!rst_b)
      rx.valid && rx.eof && !rx.sof && st_r.in_frame |=>
      st_r.last_len == $past(st_r.count) + `RXFL_LEN_ONE;
  endproperty
  a_len_capture: assert property (p_len_capture)
    else $error("Frame length not captured at frame end.");

  property p_frame_restart;
    @(posedge clock) disable iff (!rst_b)
      rx.valid && rx.sof |=>
      st_r.count == `RXFL_LEN_ONE;
  endproperty
  a_frame_restart: assert property (p_frame_restart)
    else $error("Frame start did not restart the count.");

  property p_len_read;
    @(posedge clock) disable iff (!rst_b)
      reg_rd && acc && reg_addr == `RXFL_OFF_LAST_LEN |=>
      reg_rdata == $past(st_r.last_len);
  endproperty
  a_len_read: assert property (p_len_read)
    else $error("Length read data wrong.");

  property p_valid_link;
    @(posedge clock) disable iff (!rst_b)
      last_len_valid == link_up;
  endproperty
  a_valid_link: assert property (p_valid_link)
    else $error("Length validity not tied to link.");

  // ==========================================================================
  // Cover points
  // selector written
  c_sel_write: cover property (@(posedge clock)
    reg_wr && acc && reg_addr == `RXFL_OFF_DEPTH_MODE);
  c_frame_done: cover property (@(posedge clock)
    rx.valid && rx.eof && st_r.in_frame);
  c_len_read: cover property (@(posedge clock)
    reg_rd && acc && reg_addr == `RXFL_OFF_LAST_LEN);
  c_legacy_ext: cover property (@(posedge clock)
    legacy_ext_en && !legacy_long_en);
  c_frame_restart: cover property (@(posedge clock)
    rx.valid && rx.sof && st_r.in_frame);

endmodule

// ### tb/rxfl_regs_test.sv
// Purpose: Self-checking bench for the receive depth and last frame length registers.
// Assumes: Bench sets every input by blocking assignment at time zero, then drives inputs on the rising edge by non-blocking assignment.
// Notes:   Shadow gate, legacy inputs and link are driven directly as levels.
`timescale 1ns/1ps
`include "rxfl_map.svh"
module rxfl_regs_test
  import rxfl_pkg::*;
();
  logic clock, rst_b, reg_wr, reg_rd, shadow_en, legacy_ext_en, legacy_long_en, link_up, last_len_valid;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [6:0]  rx_depth_bits;
  rxfl_rx_t    rx;
  int          mismatches = 0;
  int          n_tests = 0;
  rxfl_regs i_rxfl_regs (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shadow_en(shadow_en),
    .legacy_ext_en(legacy_ext_en), .legacy_long_en(legacy_long_en), .link_up(link_up), .rx(rx),
    .rx_depth_bits(rx_depth_bits), .last_len_valid(last_len_valid));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========
  // Tasks
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx <= '{1'b1, i == 0, i == n - 1};
    end
    @(posedge clock);
    rx <= '0;
  endtask
  task lvl(input logic e, input logic l, input logic [15:0] x);
    @(posedge clock);
    legacy_ext_en <= e; legacy_long_en <= l;
    #1 chk("depth", x, {9'h000, rx_depth_bits});
  endtask
  task finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Tests
  task t_reset;
    rd(8'h3A); chk("mode", 16'h0004, d);
    rd(8'h3C); chk("len", 16'h0000, d);
    chk("depth", 16'h001C, {9'h000, rx_depth_bits});
    $display("test reset done");
  endtask
  task t_decode;
    for (int c = 0; c < 14; c++) begin
      wr(8'h3A, 16'(c)); rd(8'h3A); chk("mode", 16'(c), d);
      chk("depth", 16'(12 + 4 * c), {9'h000, rx_depth_bits});
    end
    wr(8'h3A, 16'h000F); rd(8'h3A); chk("mode", 16'h000F, d);
    chk("depth", 16'h0040, {9'h000, rx_depth_bits});
    wr(8'h3C, 16'hFFFF); rd(8'h3C); chk("len", 16'h0000, d);
    rd(8'h20); chk("unmapped", 16'h0000, d);
    $display("test decode done");
  endtask
  task t_legacy;
    wr(8'h3A, 16'h0000);
    lvl(1'b1, 1'b0, 16'h0020); lvl(1'b1, 1'b1, 16'h0040); lvl(1'b0, 1'b1, 16'h0040); lvl(1'b0, 1'b0, 16'h000C);
    $display("test legacy done");
  endtask
  task t_frame;
    send(5); rd(8'h3C); chk("len", 16'h0005, d);
    @(posedge clock) rx <= '{1'b1, 1'b0, 1'b0};
    @(posedge clock) rx <= '{1'b1, 1'b0, 1'b1};
    @(posedge clock) rx <= '0;
    rd(8'h3C); chk("len", 16'h0005, d);
    send(2); rd(8'h3C); chk("len", 16'h0002, d);
    @(posedge clock) rx <= '{1'b1, 1'b1, 1'b0};
    @(posedge clock) rx <= '{1'b1, 1'b0, 1'b0};
    send(3); rd(8'h3C); chk("len", 16'h0003, d);
    chk("valid", 16'h0001, {15'h0000, last_len_valid});
    @(posedge clock) link_up <= 1'b0;
    #1 chk("valid", 16'h0000, {15'h0000, last_len_valid});
    $display("test frame done");
  endtask
  task t_gate;
    @(posedge clock) shadow_en <= 1'b0;
    wr(8'h3A, 16'h0001); rd(8'h3A); chk("gated", 16'h0000, d);
    @(posedge clock) shadow_en <= 1'b1;
    rd(8'h3A); chk("mode", 16'h0000, d);
    $display("test gate done");
  endtask
  initial begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
    shadow_en = 1'b1; legacy_ext_en = 1'b0; legacy_long_en = 1'b0; link_up = 1'b1; rx = '0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    t_reset; t_decode; t_legacy; t_frame; t_gate;
    finish_test;
  end
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
endmodule
